// ---- wpm_pkg.sv ----
// Purpose: shared constants and types for the performance monitor block
// Assumes: pclk at 100 MHz, APB register access with 32-bit data
// Notes: all offsets are byte addresses on the APB
package wpm_pkg;
  // clock and persistence timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LCD_SET_TIME_US = 3000; // defect must persist longer than this
  localparam int LCD_CLR_TIME_US = 1000; // absence needed before the defect clears
  localparam int LCD_SET_CYCLES = (LCD_SET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LCD_CLR_CYCLES = (LCD_CLR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_PERIOD_RST = 100000000; // one second of pclk by default

  // counter geometry
  localparam int NUM_CNT = 5;
  localparam int INC_W = 11; // wide enough for 1536 errors in one frame
  localparam int CNT_W = 32;
  localparam int HALF_W = 16;
  localparam int IDX_SECTION = 0;
  localparam int IDX_LINE = 1;
  localparam int IDX_PATH = 2;
  localparam int IDX_FAR_PATH = 3;
  localparam int IDX_FAR_LINE = 4;
  localparam logic [NUM_CNT-1:0] BLOCK_CAPABLE = 5'h0F; // far line has no block mode

  // register offsets
  localparam logic [7:0] OFS_TICK_CTRL = 8'h00;
  localparam logic [7:0] OFS_TICK_PERIOD = 8'h04;
  localparam logic [7:0] OFS_CNT_CFG = 8'h08;
  localparam logic [7:0] OFS_TX_TANDEM_OCTET_VALUE = 8'h0C;
  localparam logic [7:0] OFS_EVENT = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [1:0] REGION_STD = 2'h1; // paddr[7:6] of standard counters, 0x40
  localparam logic [1:0] REGION_STAT = 2'h2; // paddr[7:6] of statistics counters, 0x80

  // field positions
  localparam int TC_FORCE_BIT = 0;
  localparam int TC_ENA_BIT = 1;
  localparam int TC_SRC_BIT = 2;
  localparam int EV_LATCHED_BIT = 0;
  localparam int EV_DELIN_PEND_BIT = 1;
  localparam int EV_SNAP_PEND_BIT = 2;
  localparam int EV_DEFECT_BIT = 3;
  localparam int EV_BACKREP_BIT = 4;
  localparam int IE_DELIN_A_BIT = 0;
  localparam int IE_DELIN_B_BIT = 1;
  localparam int IE_SNAP_A_BIT = 2;
  localparam int IE_SNAP_B_BIT = 3;

  // reset values
  localparam logic [7:0] TX_TANDEM_OCTET_VALUE_RST = 8'h00;
  localparam logic [NUM_CNT-1:0] CNT_CFG_RST = 5'h00;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;

  // per-frame error counts from the receive overhead logic
  typedef struct packed {
    logic frame_valid;
    logic [INC_W-1:0] section;
    logic [INC_W-1:0] line;
    logic [INC_W-1:0] path;
    logic [INC_W-1:0] far_path;
    logic [INC_W-1:0] far_line;
  } wpm_err_t;
endpackage

// ---- wpm_top.sv ----
// Purpose: performance counters, snapshot tick, delineation-loss alarm, N1 octet
// Assumes: error counts and PCS alarm are synchronous to pclk; tick pin is not
// Notes: APB slave with no wait states; every access completes in its first access cycle
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE_01: N1 octet sent from programmable register
// RULE_02: delineation loss sets latched and pending bits
// RULE_03: delineation pending drives masked interrupts A, B
// RULE_04: back-report defect persisting more than 3 ms
// RULE_05: back-report from reset until delineation valid
// RULE_06: defect clears after 1 ms continuous absence
// RULE_07: standard and statistics counter for each error
// RULE_08: high-half read latches live standard count
// RULE_09: low-half read returns value latched earlier
// RULE_10: tick copies all statistics, clears internal counters
// RULE_11: forced tick works regardless of enable
// RULE_12: internal timer ticks every programmed period
// RULE_13: timer runs on receive path clock
// RULE_14: tick pin rising edge ticks in external mode
// RULE_15: every tick sets pending, masked onto interrupts
// RULE_16: statistics counters saturate, never wrap
// RULE_17: absorb 8 or 1536 increments per frame
// RULE_18: per-counter mode bit, bitwise or block
// RULE_19: block mode adds at most one per frame
// RULE_20: manager polls often enough for accurate values
// RULE_21: far path counter also offers block mode
// RULE_22: statistics counters 32 bits, high/low registers
module wpm_top #(
  parameter int P_LCD_SET_CYCLES = wpm_pkg::LCD_SET_CYCLES,
  parameter int P_LCD_CLR_CYCLES = wpm_pkg::LCD_CLR_CYCLES,
  parameter logic [31:0] P_TICK_PERIOD_RST = 32'(wpm_pkg::TICK_PERIOD_RST)
) (
  // clock and reset (pclk doubles as the receive path clock)
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive side inputs
  input wire wpm_pkg::wpm_err_t err_in,
  input wire logic pcs_delineation_loss,
  input wire logic snapshot_tick_pin,
  // outputs
  output logic [7:0] tx_tandem_octet_value,
  output logic delineation_back_report,
  output logic monitor_snapshot_tick,
  output logic irq_out_a,
  output logic irq_out_b
);
  localparam int N = wpm_pkg::NUM_CNT;

  // saturating add for the statistics counters
  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [10:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {22'h000000, b};
    sat_add = s[32] ? 32'hFFFFFFFF : s[31:0];
  endfunction

  // counter address decode: valid index in the std or stat region
  function automatic logic cnt_hit(input logic [7:0] a, input logic [1:0] region);
    cnt_hit = (a[7:6] == region) && (a[1:0] == 2'h0) && (int'(a[5:3]) < N);
  endfunction

  // apb state
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_val; // read mux result
  logic rd_ok; // address maps to a register
  wire logic apb_setup = psel & ~penable;
  wire logic apb_done = psel & penable & pready_r;
  wire logic wr_done = apb_done & pwrite;
  wire logic rd_done = apb_done & ~pwrite;
  wire logic [2:0] cnt_idx = paddr[5:3];
  wire logic cnt_hi = ~paddr[2];

  // software registers
  logic snapshot_auto_enable;
  logic snapshot_source_internal;
  logic [31:0] snapshot_period_count;
  logic [N-1:0] cnt_cfg_r; // block mode per counter
  logic [7:0] tx_tandem_octet_value_r;
  logic [3:0] irq_en_r;

  // events and status
  logic delineation_loss_latched;
  logic delineation_loss_pending;
  logic snapshot_event_pending;
  logic defect_r; // back-reported defect
  logic [31:0] on_cnt_r; // cycles alarm has been present
  logic [31:0] off_cnt_r; // cycles alarm has been absent
  logic lcd_prev_r;

  // tick path
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic [31:0] per_cnt_r;
  logic tick_r;
  logic irq_a_r;
  logic irq_b_r;

  // counters
  logic [31:0] std_live_r [N];
  logic [31:0] std_hold_r [N];
  logic [31:0] acc_r [N];
  logic [31:0] snap_r [N];
  // width must be known before the increment array is declared
  localparam int INC_W_L = wpm_pkg::INC_W;
  logic [INC_W_L-1:0] inc [N];

  // event bits that a status read may clear
  wire logic [2:0] ev_clr = (rd_done && paddr == wpm_pkg::OFS_EVENT) ? prdata_r[2:0] : 3'h0;
  wire logic force_hit = wr_done && paddr == wpm_pkg::OFS_TICK_CTRL && pwdata[wpm_pkg::TC_FORCE_BIT];
  wire logic timer_on = snapshot_auto_enable & snapshot_source_internal;
  wire logic timer_expire = timer_on && snapshot_period_count != 32'h0 &&
                            per_cnt_r >= snapshot_period_count - 32'h1;
  wire logic pin_rise = pin_s2_r & ~pin_s3_r;
  wire logic ext_tick = snapshot_auto_enable & ~snapshot_source_internal & pin_rise;

  // read mux, looked up during the setup cycle
  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    if (cnt_hit(paddr, wpm_pkg::REGION_STD)) begin
      // high half shows live count, low half the copy taken at the high read
      rd_val = cnt_hi ? {16'h0, std_live_r[cnt_idx][31:16]} : {16'h0, std_hold_r[cnt_idx][15:0]}; // RULE_08 RULE_09
    end else if (cnt_hit(paddr, wpm_pkg::REGION_STAT)) begin
      rd_val = cnt_hi ? {16'h0, snap_r[cnt_idx][31:16]} : {16'h0, snap_r[cnt_idx][15:0]}; // RULE_22
    end else begin
      unique case (paddr)
        wpm_pkg::OFS_TICK_CTRL: rd_val = {29'h0, snapshot_source_internal, snapshot_auto_enable, 1'b0};
        wpm_pkg::OFS_TICK_PERIOD: rd_val = snapshot_period_count;
        wpm_pkg::OFS_CNT_CFG: rd_val = {27'h0, cnt_cfg_r};
        wpm_pkg::OFS_TX_TANDEM_OCTET_VALUE: rd_val = {24'h0, tx_tandem_octet_value_r};
        wpm_pkg::OFS_EVENT: rd_val = {27'h0, defect_r, pcs_delineation_loss, snapshot_event_pending,
                                      delineation_loss_pending, delineation_loss_latched};
        wpm_pkg::OFS_IRQ_EN: rd_val = {28'h0, irq_en_r};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // apb handshake: no wait states, data captured at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= apb_setup;
      if (apb_setup) begin
        pslverr_r <= ~rd_ok;
        prdata_r <= pwrite ? 32'h0 : rd_val;
      end
    end
  end

  // software-written control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snapshot_auto_enable <= 1'b0;
      snapshot_source_internal <= 1'b0;
      snapshot_period_count <= P_TICK_PERIOD_RST;
      cnt_cfg_r <= wpm_pkg::CNT_CFG_RST;
      tx_tandem_octet_value_r <= wpm_pkg::TX_TANDEM_OCTET_VALUE_RST;
      irq_en_r <= wpm_pkg::IRQ_EN_RST;
    end else if (wr_done) begin
      unique case (paddr)
        wpm_pkg::OFS_TICK_CTRL: begin
          snapshot_auto_enable <= pwdata[wpm_pkg::TC_ENA_BIT];
          snapshot_source_internal <= pwdata[wpm_pkg::TC_SRC_BIT];
        end
        wpm_pkg::OFS_TICK_PERIOD: snapshot_period_count <= pwdata;
        wpm_pkg::OFS_CNT_CFG: cnt_cfg_r <= pwdata[N-1:0] & wpm_pkg::BLOCK_CAPABLE; // RULE_18 RULE_21
        wpm_pkg::OFS_TX_TANDEM_OCTET_VALUE: tx_tandem_octet_value_r <= pwdata[7:0]; // RULE_01
        wpm_pkg::OFS_IRQ_EN: irq_en_r <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // tick pin synchroniser plus one stage for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= snapshot_tick_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // period timer on pclk, the receive path clock; drifts if that clock does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 32'h0;
    end else if (timer_expire || !timer_on) begin
      per_cnt_r <= 32'h0; // RULE_12 RULE_13
    end else begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  // tick merge: force ignores enable, others need it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= force_hit | timer_expire | ext_tick; // RULE_11 RULE_12 RULE_14
    end
  end

  // alarm persistence counters, saturating so they never roll back to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt_r <= 32'h0;
      off_cnt_r <= 32'h0;
      lcd_prev_r <= 1'b0;
    end else begin
      lcd_prev_r <= pcs_delineation_loss;
      if (pcs_delineation_loss) begin
        off_cnt_r <= 32'h0;
        if (on_cnt_r < 32'(P_LCD_SET_CYCLES)) on_cnt_r <= on_cnt_r + 32'h1;
      end else begin
        on_cnt_r <= 32'h0;
        if (off_cnt_r < 32'(P_LCD_CLR_CYCLES)) off_cnt_r <= off_cnt_r + 32'h1;
      end
    end
  end

  // defect is up from reset until the alarm has been gone long enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      defect_r <= 1'b1; // RULE_05
    end else if (pcs_delineation_loss && on_cnt_r >= 32'(P_LCD_SET_CYCLES)) begin
      defect_r <= 1'b1; // RULE_04
    end else if (!pcs_delineation_loss && off_cnt_r >= 32'(P_LCD_CLR_CYCLES - 1)) begin
      defect_r <= 1'b0; // RULE_06
    end
  end

  // sticky event bits; a new event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delineation_loss_latched <= 1'b0;
      delineation_loss_pending <= 1'b0;
      snapshot_event_pending <= 1'b0;
    end else begin
      delineation_loss_latched <= pcs_delineation_loss | (delineation_loss_latched & ~ev_clr[0]); // RULE_02
      delineation_loss_pending <= (pcs_delineation_loss & ~lcd_prev_r) |
                                  (delineation_loss_pending & ~ev_clr[1]); // RULE_02
      snapshot_event_pending <= tick_r | (snapshot_event_pending & ~ev_clr[2]); // RULE_15
    end
  end

  // interrupt outputs, each source gated by its own enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end else begin
      irq_a_r <= (delineation_loss_pending & irq_en_r[wpm_pkg::IE_DELIN_A_BIT]) |
                 (snapshot_event_pending & irq_en_r[wpm_pkg::IE_SNAP_A_BIT]); // RULE_03 RULE_15
      irq_b_r <= (delineation_loss_pending & irq_en_r[wpm_pkg::IE_DELIN_B_BIT]) |
                 (snapshot_event_pending & irq_en_r[wpm_pkg::IE_SNAP_B_BIT]); // RULE_03 RULE_15
    end
  end

  // per-frame increments in counter order
  assign inc[wpm_pkg::IDX_SECTION] = err_in.section;
  assign inc[wpm_pkg::IDX_LINE] = err_in.line;
  assign inc[wpm_pkg::IDX_PATH] = err_in.path;
  assign inc[wpm_pkg::IDX_FAR_PATH] = err_in.far_path;
  assign inc[wpm_pkg::IDX_FAR_LINE] = err_in.far_line;

  // one standard and one statistics counter per error type
  for (genvar i = 0; i < N; i++) begin : g_cnt
    logic [INC_W_L-1:0] step; // increment after mode selection
    logic [31:0] acc_sum;
    always_comb begin
      step = 11'h000;
      if (err_in.frame_valid) begin
        // block mode counts an errored frame once
        step = cnt_cfg_r[i] ? {10'h000, |inc[i]} : inc[i]; // RULE_17 RULE_18 RULE_19 RULE_21
      end
    end
    assign acc_sum = sat_add(acc_r[i], step);

    // standard counter: free running, copied on a high-half read
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        std_live_r[i] <= 32'h0;
        std_hold_r[i] <= 32'h0;
      end else begin
        std_live_r[i] <= std_live_r[i] + {21'h0, step}; // RULE_07
        if (apb_setup && !pwrite && cnt_hit(paddr, wpm_pkg::REGION_STD) && cnt_idx == 3'(i) && cnt_hi) begin
          std_hold_r[i] <= std_live_r[i]; // RULE_08
        end
      end
    end

    // statistics counter: snapshot and clear together on a tick
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_r[i] <= 32'h0;
        snap_r[i] <= 32'h0;
      end else if (tick_r) begin
        snap_r[i] <= acc_sum; // RULE_10 RULE_07
        acc_r[i] <= 32'h0; // RULE_10
      end else begin
        acc_r[i] <= acc_sum; // RULE_16
      end
    end
  end

  // outputs straight from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_tandem_octet_value = tx_tandem_octet_value_r;
  assign delineation_back_report = defect_r;
  assign monitor_snapshot_tick = tick_r;
  assign irq_out_a = irq_a_r;
  assign irq_out_b = irq_b_r;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  n1_write_a: assert property (wr_done && paddr == wpm_pkg::OFS_TX_TANDEM_OCTET_VALUE |=> tx_tandem_octet_value == $past(pwdata[7:0])) // RULE_01
    else $error("n1 octet not taken from write");
  delin_latch_a: assert property (pcs_delineation_loss |=> delineation_loss_latched) // RULE_02
    else $error("latched delineation bit missing");
  irq_a_gate_a: assert property (delineation_loss_pending && irq_en_r[0] |=> irq_out_a) // RULE_03
    else $error("interrupt a not raised");
  irq_b_gate_a: assert property (snapshot_event_pending && irq_en_r[wpm_pkg::IE_SNAP_B_BIT] |=> irq_out_b) // RULE_15
    else $error("interrupt b not raised");
  backrep_set_a: assert property ($rose(defect_r) |-> $past(on_cnt_r) >= 32'(P_LCD_SET_CYCLES)) // RULE_04
    else $error("back report raised too early");
  backrep_hold_a: assert property (defect_r && pcs_delineation_loss |=> defect_r) // RULE_05
    else $error("defect dropped while alarm present");
  backrep_clear_a: assert property ($fell(defect_r) |-> $past(off_cnt_r) >= 32'(P_LCD_CLR_CYCLES - 1)) // RULE_06
    else $error("defect cleared too early");
  low_read_a: assert property (apb_setup && !pwrite && cnt_hit(paddr, wpm_pkg::REGION_STD) && !cnt_hi
                               |=> prdata[15:0] == $past(std_hold_r[cnt_idx][15:0])) // RULE_09
    else $error("low half not from held copy");
  tick_clear_a: assert property (tick_r |=> acc_r[0] == 32'h0 && acc_r[1] == 32'h0) // RULE_10
    else $error("statistics not cleared on tick");
  force_tick_a: assert property (force_hit |=> tick_r ##1 snapshot_event_pending) // RULE_11
    else $error("forced tick lost");
  pin_tick_a: assert property (ext_tick |=> tick_r) // RULE_14
    else $error("pin edge did not tick");
  sat_hold_a: assert property (acc_r[1] == 32'hFFFFFFFF && !tick_r |=> acc_r[1] == 32'hFFFFFFFF) // RULE_16
    else $error("statistics counter wrapped");
  block_step_a: assert property (cnt_cfg_r[0] && !tick_r |=> acc_r[0] - $past(acc_r[0]) <= 32'h1) // RULE_19
    else $error("block mode added more than one");
  timer_tick_c: cover property (timer_expire ##1 tick_r);
  pin_tick_c: cover property (ext_tick ##1 tick_r);
  backrep_c: cover property ($fell(defect_r));
  std_pair_c: cover property (rd_done && cnt_hit(paddr, wpm_pkg::REGION_STD) && !cnt_hi);
  force_tick_c: cover property (force_hit ##2 snapshot_event_pending);
endmodule
`default_nettype wire

// ---- wpm_rx_source.sv ----
// Purpose: far-side model of the receive overhead logic and the PCS alarm
// Assumes: bench raises send for exactly one cycle per frame
// Notes: counts outside a frame carry a moving pattern, never a stale value
`timescale 1ns/100ps
`default_nettype none
module wpm_rx_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the bench
  input wire logic send,
  input wire wpm_pkg::wpm_err_t req,
  input wire logic loss_req,
  // toward the design
  output wpm_pkg::wpm_err_t err_out,
  output logic pcs_loss
);
  logic [10:0] junk_r; // filler so idle counts are never mistaken for valid

  // filler changes every cycle, a design counting outside frames will drift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_r <= 11'h7FF;
    end else begin
      junk_r <= junk_r + 11'h123;
    end
  end

  // one frame strobe per request, counts up to 1536 per field
  always_comb begin
    if (send) begin
      err_out = {1'b1, req[54:0]};
    end else begin
      err_out = {1'b0, {5{junk_r}}};
    end
  end

  // pcs alarm is a plain level, same clock
  assign pcs_loss = loss_req;
endmodule
`default_nettype wire

// ---- test_wpm_perf_monitor_counters.sv ----
// Purpose: self-checking bench for the performance monitor block
// Assumes: one-cycle APB access phase, tick pulse seen one cycle after the cause
// Notes: persistence counts shortened by parameters; saturation is left to assertions
`timescale 1ns/100ps
`default_nettype none
module test_wpm_perf_monitor_counters;
  localparam int SET_CYC = 20; // shortened persistence before back-report
  localparam int CLR_CYC = 10; // shortened absence before clearing
  // bus, pins and model requests
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, n1;
  logic [31:0] pwdata, prdata, rd;
  logic send, loss_req, pcs_loss, tick_pin, back_rep, snap_tick, irq_a, irq_b;
  wpm_pkg::wpm_err_t err_in, frame_req;
  int err_total, n_checks, n_ticks, cyc, last_cyc, t, c1;

  wpm_top #(.P_LCD_SET_CYCLES(SET_CYC), .P_LCD_CLR_CYCLES(CLR_CYC), .P_TICK_PERIOD_RST(32'h0000_0064)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .err_in(err_in),
    .pcs_delineation_loss(pcs_loss), .snapshot_tick_pin(tick_pin), .tx_tandem_octet_value(n1),
    .delineation_back_report(back_rep), .monitor_snapshot_tick(snap_tick), .irq_out_a(irq_a),
    .irq_out_b(irq_b));
  wpm_rx_source src_u (.pclk(pclk), .presetn(presetn), .send(send), .req(frame_req),
    .loss_req(loss_req), .err_out(err_in), .pcs_loss(pcs_loss));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // tick watcher, counts pulses and remembers their cycle
  always @(posedge pclk) begin
    cyc++;
    if (snap_tick === 1'b1) begin
      n_ticks++;
      last_cyc = cyc;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) chk(1'b0, 1'b1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // one frame of error counts through the model
  task automatic frame(input logic [10:0] s, l, p, fp, fl);
    @(posedge pclk);
    send <= 1'b1;
    frame_req <= {1'b0, s, l, p, fp, fl};
    @(posedge pclk);
    send <= 1'b0;
  endtask

  // bounded wait for the tick count to reach a figure
  task automatic wait_tick(input int n_exp);
    int k;
    k = 0;
    while (n_ticks < n_exp && k < 300) begin
      @(posedge pclk);
      #1;
      k++;
    end
    chk(n_ticks, n_exp);
  endtask

  task automatic force_tick();
    t = n_ticks;
    apb(1'b1, wpm_pkg::OFS_TICK_CTRL, 32'h0000_0001);
    wait_tick(t + 1);
    cycles(3);
  endtask

  // snapshot registers, high half then low half, joined
  task automatic stat_chk(input logic [31:0] e [5]);
    logic [31:0] hi;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'h80 + 8'(8 * i), 32'h0000_0000);
      hi = rd;
      apb(1'b0, 8'h84 + 8'(8 * i), 32'h0000_0000);
      chk({hi[15:0], rd[15:0]}, e[i]);
    end
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("BAD t=%0t run did not finish", $time);
    report_and_stop();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, send, loss_req, tick_pin} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    frame_req = '0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cycles(2);
    chk(back_rep, 1'b1);
    chk(n1, 8'h00);
    cycles(CLR_CYC + 5);
    chk(back_rep, 1'b0);
    apb(1'b1, wpm_pkg::OFS_TX_TANDEM_OCTET_VALUE, 32'h0000_00A5);
    rchk(wpm_pkg::OFS_TX_TANDEM_OCTET_VALUE, 32'h0000_00A5);
    chk(n1, 8'hA5);
    rchk(8'h30, 32'h0000_0000);
    chk(er, 1'b1);
    rchk(wpm_pkg::OFS_TICK_PERIOD, 32'h0000_0064);
    $display("test reset and n1 done");
    // short alarm burst, too brief to back-report
    apb(1'b1, wpm_pkg::OFS_IRQ_EN, 32'h0000_0001);
    @(posedge pclk);
    loss_req <= 1'b1;
    cycles(CLR_CYC);
    @(posedge pclk);
    loss_req <= 1'b0;
    cycles(SET_CYC);
    chk(back_rep, 1'b0);
    chk({irq_a, irq_b}, 2'b10);
    rchk(wpm_pkg::OFS_EVENT, 32'h0000_0003);
    rchk(wpm_pkg::OFS_EVENT, 32'h0000_0000);
    cycles(2);
    chk(irq_a, 1'b0);
    // persistent alarm, then its removal; pending routed to output b only
    apb(1'b1, wpm_pkg::OFS_IRQ_EN, 32'h0000_0002);
    @(posedge pclk);
    loss_req <= 1'b1;
    cycles(SET_CYC - 5);
    chk(back_rep, 1'b0);
    cycles(10);
    chk(back_rep, 1'b1);
    chk({irq_a, irq_b}, 2'b01);
    @(posedge pclk);
    loss_req <= 1'b0;
    cycles(CLR_CYC - 5);
    chk(back_rep, 1'b1);
    cycles(10);
    chk(back_rep, 1'b0);
    $display("test delineation done");
    // counters: heavy line errors cross the 16-bit half
    for (int i = 0; i < 50; i++) frame(11'd0, 11'd1536, 11'd8, 11'd8, 11'd1536);
    frame(11'd5, 11'd0, 11'd0, 11'd0, 11'd0);
    frame(11'd5, 11'd0, 11'd0, 11'd0, 11'd0);
    rchk(8'h40, 32'h0000_0000);
    frame(11'd3, 11'd0, 11'd0, 11'd0, 11'd0);
    rchk(8'h44, 32'h0000_000A);
    rchk(8'h40, 32'h0000_0000);
    rchk(8'h44, 32'h0000_000D);
    rchk(8'h48, 32'h0000_0001);
    rchk(8'h4C, 32'h0000_2C00);
    force_tick();
    stat_chk('{32'd13, 32'd76800, 32'd400, 32'd400, 32'd76800});
    force_tick();
    stat_chk('{32'd0, 32'd0, 32'd0, 32'd0, 32'd0});
    $display("test counters done");
    // block counting on the four capable counters
    apb(1'b1, wpm_pkg::OFS_CNT_CFG, 32'h0000_000F);
    rchk(wpm_pkg::OFS_CNT_CFG, 32'h0000_000F);
    frame(11'd7, 11'd7, 11'd7, 11'd7, 11'd7);
    frame(11'd0, 11'd0, 11'd0, 11'd0, 11'd0);
    frame(11'd7, 11'd7, 11'd7, 11'd7, 11'd7);
    force_tick();
    stat_chk('{32'd2, 32'd2, 32'd2, 32'd2, 32'd14});
    $display("test block mode done");
    // snapshot pending onto output b only
    apb(1'b0, wpm_pkg::OFS_EVENT, 32'h0000_0000);
    apb(1'b1, wpm_pkg::OFS_IRQ_EN, 32'h0000_0008);
    force_tick();
    chk({irq_a, irq_b}, 2'b01);
    rchk(wpm_pkg::OFS_EVENT, 32'h0000_0004);
    cycles(3);
    chk(irq_b, 1'b0);
    // periodic timer, then disabled
    apb(1'b1, wpm_pkg::OFS_TICK_PERIOD, 32'h0000_0032);
    apb(1'b1, wpm_pkg::OFS_TICK_CTRL, 32'h0000_0006);
    t = n_ticks;
    wait_tick(t + 1);
    c1 = last_cyc;
    wait_tick(t + 2);
    chk(32'(last_cyc - c1), 32'd50);
    apb(1'b1, wpm_pkg::OFS_TICK_CTRL, 32'h0000_0000);
    cycles(2);
    t = n_ticks;
    cycles(120);
    chk(n_ticks, t);
    // pin edge ticks only when enabled in external mode
    apb(1'b1, wpm_pkg::OFS_TICK_CTRL, 32'h0000_0002);
    @(posedge pclk);
    tick_pin <= 1'b1;
    wait_tick(t + 1);
    @(posedge pclk);
    tick_pin <= 1'b0;
    apb(1'b1, wpm_pkg::OFS_TICK_CTRL, 32'h0000_0000);
    t = n_ticks;
    @(posedge pclk);
    tick_pin <= 1'b1;
    cycles(10);
    chk(n_ticks, t);
    $display("test tick sources done");
    report_and_stop();
  end
endmodule
`default_nettype wire
